// ==== hw/hsis_pkg.sv ====
// shared constants and types of the host serial interface select and spi slave
package hsis_pkg;

	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam int HSIS_BYTE_BITS = 8;
	localparam int HSIS_INDEX_BITS = 7;
	localparam logic [2:0] HSIS_BIT_FIRST = 3'h0;
	localparam logic [2:0] HSIS_BIT_LAST = 3'h7;
	localparam logic [2:0] HSIS_BIT_STEP = 3'h1;
	localparam logic HSIS_DIR_READ = 1'h1;
	localparam logic [6:0] HSIS_INDEX_STEP = 7'h01;
	localparam logic [6:0] HSIS_INDEX_RESET = 7'h00;
	localparam logic [7:0] HSIS_BYTE_RESET = 8'h00;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		HSIS_IDLE,
		HSIS_CONTROL,
		HSIS_WRITE_DATA,
		HSIS_READ_DATA
	} hsis_phase_type;

	// request towards the register file of the device
	typedef struct packed {
		logic read;
		logic write;
		logic [6:0] index;
		logic [7:0] wdata;
	} hsis_reg_req_type;

	typedef struct packed {
		logic sel_s1;
		logic sel_s2;
		logic sel_d;
		logic sck_s1;
		logic sck_s2;
		logic sck_d;
		logic sdi_s1;
		logic sdi_s2;
		logic spi_latched;
		logic mode11;
		hsis_phase_type phase;
		logic [2:0] bit_cnt;
		logic [7:0] shift;
		logic load_pending;
		logic out_bit;
		logic drive_4w;
		logic drive_3w;
		hsis_reg_req_type req;
	} hsis_state_type;

	// select idles high, and the clock idles high in mode 11, so their syncs start high to avoid a false edge
	localparam hsis_state_type HSIS_STATE_RESET = '{
		sel_s1: 1'h1,
		sel_s2: 1'h1,
		sel_d: 1'h1,
		sck_s1: 1'h1,
		sck_s2: 1'h1,
		sck_d: 1'h1,
		sdi_s1: 1'h0,
		sdi_s2: 1'h0,
		spi_latched: 1'h0,
		mode11: 1'h0,
		phase: HSIS_IDLE,
		bit_cnt: HSIS_BIT_FIRST,
		shift: HSIS_BYTE_RESET,
		load_pending: 1'h0,
		out_bit: 1'h0,
		drive_4w: 1'h0,
		drive_3w: 1'h0,
		req: '{read: 1'h0, write: 1'h0, index: HSIS_INDEX_RESET, wdata: HSIS_BYTE_RESET}
	};

endpackage : hsis_pkg

// ==== hw/hsis_spi.sv ====
// host interface protocol select and oversampled spi slave
//
// How it works
// - after reset the two-wire bus is used
// - select rising edge latches spi until reset
// - nonvolatile lock bit forces spi permanently
// - modes 00 and 11 picked at select fall
// - four-wire default, three-wire when bit set
// - three-wire returns read data on data pin
// - single access is control byte plus data
// - multi-byte reads and writes per select
// - select low frames a transaction, master clocks
// - change on falling clock, sample on rising
// - serial output stays released during writes
// - first bit direction, then seven index bits
// - data byte written or returned from index
// - reads continue with incremented index
`timescale 1ns/1ps
`default_nettype none

module hsis_spi
	import hsis_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic select_low_pin,
	input wire logic serial_clock_pin,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	output logic serial_out_pin_out,
	output logic serial_out_pin_oe,
	input wire logic nonvolatile_config_spi_lock,
	input wire logic three_wire_select,
	output logic spi_selected,
	output logic mode11_detected,
	output hsis_reg_req_type reg_req,
	input wire logic [7:0] reg_rdata
);

	hsis_state_type s;
	hsis_state_type next_s;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic sel_fall;
		logic sel_rise;
		logic sck_rise;
		logic sck_fall;
		logic spi_on;
		logic [7:0] rx;
		sel_fall = 1'h0;
		sel_rise = 1'h0;
		sck_rise = 1'h0;
		sck_fall = 1'h0;
		spi_on = 1'h0;
		rx = HSIS_BYTE_RESET;
		next_s = s;

		// pins cross into the clock domain through two flops
		next_s.sel_s1 = select_low_pin;
		next_s.sel_s2 = s.sel_s1;
		next_s.sel_d = s.sel_s2;
		next_s.sck_s1 = serial_clock_pin;
		next_s.sck_s2 = s.sck_s1;
		next_s.sck_d = s.sck_s2;
		next_s.sdi_s1 = serial_data_pin_in;
		next_s.sdi_s2 = s.sdi_s1;

		sel_fall = s.sel_d & ~s.sel_s2;
		sel_rise = ~s.sel_d & s.sel_s2;
		sck_rise = ~s.sck_d & s.sck_s2;
		sck_fall = s.sck_d & ~s.sck_s2;
		rx = {s.shift[6:0], s.sdi_s2};

		spi_on = s.spi_latched | nonvolatile_config_spi_lock;
		if (sel_rise) begin
			next_s.spi_latched = 1'h1;
		end

		next_s.req.read = 1'h0;
		next_s.req.write = 1'h0;
		// index moves on only after the write strobe has used it
		if (s.req.write) begin
			next_s.req.index = s.req.index + HSIS_INDEX_STEP;
		end
		// register file answers in the same cycle as the read strobe
		if (s.load_pending) begin
			next_s.shift = reg_rdata;
			next_s.load_pending = 1'h0;
		end

		case (s.phase)
			HSIS_IDLE: begin
				// the frame that first selects spi is not served
				if (sel_fall && spi_on) begin
					next_s.phase = HSIS_CONTROL;
					next_s.bit_cnt = HSIS_BIT_FIRST;
					next_s.mode11 = s.sck_s2;
				end
			end
			HSIS_CONTROL: begin
				if (sck_rise) begin
					next_s.shift = rx;
					next_s.bit_cnt = s.bit_cnt + HSIS_BIT_STEP;
					if (s.bit_cnt == HSIS_BIT_LAST) begin
						next_s.req.index = rx[6:0];
						if (rx[7] == HSIS_DIR_READ) begin
							next_s.phase = HSIS_READ_DATA;
							next_s.req.read = 1'h1;
							next_s.load_pending = 1'h1;
						end else begin
							next_s.phase = HSIS_WRITE_DATA;
						end
					end
				end
			end
			HSIS_WRITE_DATA: begin
				if (sck_rise) begin
					next_s.shift = rx;
					next_s.bit_cnt = s.bit_cnt + HSIS_BIT_STEP;
					if (s.bit_cnt == HSIS_BIT_LAST) begin
						next_s.req.write = 1'h1;
						next_s.req.wdata = rx;
					end
				end
			end
			HSIS_READ_DATA: begin
				if (sck_fall) begin
					next_s.out_bit = s.shift[7];
					next_s.shift = {s.shift[6:0], 1'h0};
					next_s.drive_4w = ~three_wire_select;
					next_s.drive_3w = three_wire_select;
				end
				if (sck_rise) begin
					next_s.bit_cnt = s.bit_cnt + HSIS_BIT_STEP;
					if (s.bit_cnt == HSIS_BIT_LAST) begin
						next_s.req.index = s.req.index + HSIS_INDEX_STEP;
						next_s.req.read = 1'h1;
						next_s.load_pending = 1'h1;
					end
				end
			end
			default: begin
				next_s.phase = HSIS_IDLE;
			end
		endcase

		// end of frame wins over any bit in flight
		if (sel_rise && s.phase != HSIS_IDLE) begin
			next_s.phase = HSIS_IDLE;
			next_s.bit_cnt = HSIS_BIT_FIRST;
			next_s.drive_4w = 1'h0;
			next_s.drive_3w = 1'h0;
			next_s.load_pending = 1'h0;
		end
		// writes never drive either data pin
		if (s.phase != HSIS_READ_DATA) begin
			next_s.drive_4w = 1'h0;
			next_s.drive_3w = 1'h0;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s <= HSIS_STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign serial_out_pin_out = s.out_bit;
	assign serial_out_pin_oe = s.drive_4w;
	assign serial_data_pin_out = s.out_bit;
	assign serial_data_pin_oe = s.drive_3w;
	assign spi_selected = s.spi_latched | nonvolatile_config_spi_lock;
	assign mode11_detected = s.mode11;
	assign reg_req = s.req;

endmodule : hsis_spi

`default_nettype wire

// ==== verification/hsis_spi_asserts.sv ====
// port assertions of the host serial interface block
`timescale 1ns/1ps
`default_nettype none
module hsis_spi_asserts
	import hsis_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic select_low_pin,
	input wire logic serial_clock_pin,
	input wire logic serial_data_pin_oe,
	input wire logic serial_out_pin_oe,
	input wire logic nonvolatile_config_spi_lock,
	input wire logic three_wire_select,
	input wire logic spi_selected,
	input wire logic mode11_detected,
	input wire hsis_reg_req_type reg_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	property p_idle; !spi_selected |-> !serial_out_pin_oe && !reg_req.read; endproperty
	a_idle: assert property (p_idle) else $error("served off");
	property p_keep; spi_selected && !nonvolatile_config_spi_lock |=> spi_selected; endproperty
	a_keep: assert property (p_keep) else $error("spi lost");
	property p_lock; nonvolatile_config_spi_lock |-> spi_selected; endproperty
	a_lock: assert property (p_lock) else $error("lock");
	property p_mode;
		$fell(select_low_pin) && spi_selected |-> ##5 mode11_detected == $past(serial_clock_pin, 5);
	endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_tw; serial_data_pin_oe |-> three_wire_select; endproperty
	a_tw: assert property (p_tw) else $error("data pin");
	property p_fw; serial_out_pin_oe |-> !three_wire_select; endproperty
	a_fw: assert property (p_fw) else $error("out pin");
	property p_rel; select_low_pin [*5] |-> !serial_out_pin_oe && !serial_data_pin_oe; endproperty
	a_rel: assert property (p_rel) else $error("release");
	property p_wr;
		reg_req.write |=> reg_req.index == $past(reg_req.index) + 7'h01 && !serial_out_pin_oe;
	endproperty
	a_wr: assert property (p_wr) else $error("write");
	c_wr: cover property (reg_req.write);
	c_rd: cover property (reg_req.read);
	c_tw: cover property (serial_data_pin_oe);
endmodule : hsis_spi_asserts
bind hsis_spi hsis_spi_asserts A (.*);
`default_nettype wire

// ==== verification/hsis_master.sv ====
// spi master model at the far side of the host serial interface
`timescale 1ns/1ps
`default_nettype none
module hsis_master (
	output var logic sel_b,
	output var logic sck,
	output var logic mosi,
	input wire logic miso
);
	logic [23:0] rx = 24'h0;
	initial begin
		sel_b = 1'h1;
		sck = 1'h1;
		mosi = 1'h0;
	end
	// idle sck level before select falls picks the mode
	task automatic frame(input logic m, input logic [23:0] t, input int nb);
		#22 sck = m;
		#200 sel_b = 1'h0;
		// keep the clock at its idle level past the select fall so the mode is sampled cleanly
		#200;
		for (int i = 0; i < nb; i++) begin
			sck = 1'h0;
			// a read releases the pin after the control byte, so it toggles
			mosi = (i > 7 && t[23]) ? ~mosi : t[23 - i];
			#200 sck = 1'h1;
			rx = {rx[22:0], miso};
			#200;
		end
		sck = m;
		#200 sel_b = 1'h1;
		mosi = ~mosi;
		#400;
	endtask : frame
endmodule : hsis_master
`default_nettype wire

// ==== verification/hsis_spi_tb.sv ====
// self-checking bench of the host serial interface block
`timescale 1ns/1ps
`default_nettype none
module hsis_spi_tb;
	import hsis_pkg::*;
	logic clock = 1'h0;
	logic rst_b = 1'h0;
	logic nonvolatile_config_spi_lock = 1'h0;
	logic three_wire_select = 1'h0;
	logic select_low_pin, serial_clock_pin, mosi, serial_data_pin_out, serial_data_pin_oe;
	logic serial_out_pin_out, serial_out_pin_oe, spi_selected, mode11_detected;
	hsis_reg_req_type reg_req;
	logic [7:0] reg_rdata = 8'h00;
	logic [7:0] mem [128];
	int errors = 0;
	int n_tests = 0;
	// a released out pin shows the inverse of its last value
	wire serial_data_pin_in = serial_data_pin_oe ? serial_data_pin_out : mosi;
	wire miso = three_wire_select ? serial_data_pin_in : serial_out_pin_oe ^ ~serial_out_pin_out;
	always #25 clock = ~clock;
	hsis_spi DUT (.*);
	hsis_master M (.sel_b(select_low_pin), .sck(serial_clock_pin), .mosi, .miso);
	always @(negedge clock) begin
		reg_rdata <= mem[reg_req.index];
		if (reg_req.write) mem[reg_req.index] <= reg_req.wdata;
	end
	task check(input string n, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task reset(input logic l);
		@(negedge clock);
		rst_b = 1'h0;
		nonvolatile_config_spi_lock = l;
		repeat (5) @(negedge clock);
		rst_b = 1'h1;
		@(negedge clock);
	endtask : reset
	task xfer(input logic m, input logic [23:0] t, input int nb);
		@(negedge clock);
		M.frame(m, t, nb);
	endtask : xfer
	task give_verdict;
		if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		#200us;
		errors++;
		give_verdict;
	end
	initial begin
		for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
		reset(1'h0);
		check("spi_sel", 16'h0, 16'(spi_selected));
		xfer(1'h1, 24'hff0000, 16);
		check("spi_sel", 16'h1, 16'(spi_selected));
		xfer(1'h1, 24'h081234, 24);
		check("wr", 16'h1234, {mem[8], mem[9]});
		xfer(1'h0, 24'h880000, 24);
		check("rd", 16'h1234, M.rx[15:0]);
		check("mode", 16'h0, 16'(mode11_detected));
		@(negedge clock) three_wire_select = 1'h1;
		xfer(1'h1, 24'h890000, 16);
		check("rd3", 16'h34, 16'(M.rx[7:0]));
		check("mode", 16'h1, 16'(mode11_detected));
		xfer(1'h1, 24'h20ab00, 12);
		check("cut", 16'h7a, 16'(mem[32]));
		reset(1'h1);
		check("lock", 16'h1, 16'(spi_selected));
		reset(1'h0);
		check("spi_sel", 16'h0, 16'(spi_selected));
		give_verdict;
	end
endmodule : hsis_spi_tb
`default_nettype wire
